// *** rtl/emra_defs.vh ***
// Shared constants for the external memory request arbiter
`ifndef EMRA_DEFS_VH
`define EMRA_DEFS_VH

// ****************************************
// Register offsets
// ****************************************
`define EMRA_ADDR_W 4
`define EMRA_OFF_EXTERNAL_BUS_SELECT_REG 4'h0
`define EMRA_OFF_TYPE 4'h1
`define EMRA_OFF_STAT 4'h2
`define EMRA_OFF_RPEND 4'h3

// ****************************************
// Field positions and reset values
// ****************************************
`define EMRA_BIT_HOLD 0
`define EMRA_BIT_ACKN 1
`define EMRA_TYPE_RST 12'h249
`define EMRA_MT_ASYNC8 3'h0
`define EMRA_MT_ASYNC16 3'h1
`define EMRA_MT_SDRAM 3'h3

// ****************************************
// Requester indices, priority order
// ****************************************
`define EMRA_NREQ 8
`define EMRA_RQ_URG 0
`define EMRA_RQ_E 1
`define EMRA_RQ_F 2
`define EMRA_RQ_D 3
`define EMRA_RQ_C 4
`define EMRA_RQ_P 5
`define EMRA_RQ_DMA 6
`define EMRA_RQ_TRK 7

// ****************************************
// Timing counts
// ****************************************
`define EMRA_ACC_CYC 4'h3
`define EMRA_DEACT_CYC 4'h2

`endif

// *** rtl/emra_prio.v ***
// Fixed-priority picker, lowest index wins
`timescale 1ns/1ps
module emra_prio #(
    parameter N = 8
) (
    input wire [N-1:0] req,
    output reg [N-1:0] grant
);
    integer i;
    reg found;
    always @* begin
        grant = {N{1'b0}};
        found = 1'b0;
        for (i = 0; i < N; i = i + 1) begin
            if (req[i] && !found) begin
                grant[i] = 1'b1;
                found = 1'b1;
            end
        end
    end
endmodule

// *** rtl/emra_arbiter.v ***
// Request arbiter and bus-release core of the external memory port
`timescale 1ns/1ps
`include "emra_defs.vh"
module emra_arbiter #(
    parameter AW = 22,
    parameter ACC_CYC = 4,
    parameter DEACT_CYC = 2
) (
    input wire clk,
    input wire resetn,
    input wire [`EMRA_ADDR_W-1:0] reg_addr,
    input wire [15:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [15:0] reg_rdata,
    input wire [`EMRA_NREQ-1:0] req_in,
    input wire req_long,
    input wire [AW+1:0] addr_e,
    input wire [AW+1:0] addr_f,
    input wire [AW+1:0] addr_d,
    input wire [AW+1:0] addr_c,
    input wire [AW+1:0] addr_p,
    input wire [AW+1:0] addr_dma,
    input wire dma_write,
    output reg [`EMRA_NREQ-1:0] req_done,
    output reg [`EMRA_NREQ-1:0] req_drop,
    output reg [3:0] chip_space_n,
    output reg [AW+1:0] mem_addr,
    output reg mem_write,
    output reg mem_long,
    output reg mem_busy,
    output reg mem_refresh,
    output reg mem_oe
);
    // ****************************************
    // States and helpers
    // ****************************************
    localparam ST_IDLE = 3'h0;
    localparam ST_ACC = 3'h1;
    localparam ST_DEAD = 3'h2;
    localparam ST_DEACT = 3'h3;
    localparam ST_HELD = 3'h4;
    localparam ST_RFSH = 3'h5;

    function [1:0] space_of;
        input [AW+1:0] a;
        begin
            space_of = a[AW+1:AW];
        end
    endfunction

    // SDRAM of two or four spaces answers on the first space's enable
    function [1:0] enable_of;
        input [1:0] sp;
        input [11:0] types;
        begin
            enable_of = sp;
            if (types[3*sp+:3] == `EMRA_MT_SDRAM
                    && types[3*(sp ^ 2'h1)+:3] == `EMRA_MT_SDRAM) begin
                enable_of = {sp[1], 1'b0};
                if (types[3*(sp ^ 2'h2)+:3] == `EMRA_MT_SDRAM
                        && types[3*(sp ^ 2'h3)+:3] == `EMRA_MT_SDRAM) begin
                    enable_of = 2'h0;
                end
            end
        end
    endfunction

    reg [2:0] state;
    reg [2:0] next_state;
    reg hold_req;
    reg ack_n;
    reg [11:0] mem_types;
    reg [`EMRA_NREQ-1:0] pend;
    reg [3:0] cnt;
    reg [1:0] last_space;
    reg last_write;
    reg last_valid;
    reg [`EMRA_NREQ-1:0] cur;
    reg [1:0] cur_space;
    reg cur_async;
    reg [`EMRA_NREQ-1:0] drop_mask;
    reg [AW+1:0] sel_addr;
    reg sel_write;
    reg [2:0] sel_type;

    // ****************************************
    // Pending requests and arbitration
    // ****************************************
    wire [`EMRA_NREQ-1:0] all_pend = pend | req_in;
    wire refresh_due = all_pend[`EMRA_RQ_URG] | all_pend[`EMRA_RQ_TRK];
    // After a release, due refreshes go before accesses
    reg after_hold;
    wire [`EMRA_NREQ-1:0] arb_mask = after_hold && refresh_due ?
        ((`EMRA_NREQ'h1 << `EMRA_RQ_URG) | (`EMRA_NREQ'h1 << `EMRA_RQ_TRK)) :
        {`EMRA_NREQ{1'b1}};
    wire [`EMRA_NREQ-1:0] grant;

    emra_prio #(
        .N(`EMRA_NREQ)
    ) u_prio (
        .req(all_pend & arb_mask),
        .grant(grant)
    );

    // Long access: one request on D or E; its partner bus is not a request
    always @* begin
        drop_mask = {`EMRA_NREQ{1'b0}};
        if (req_long) begin
            drop_mask[`EMRA_RQ_C] = req_in[`EMRA_RQ_D];
            drop_mask[`EMRA_RQ_F] = req_in[`EMRA_RQ_E];
        end
    end

    always @* begin
        sel_addr = {(AW+2){1'b0}};
        sel_write = 1'b0;
        if (grant[`EMRA_RQ_E]) begin
            sel_addr = addr_e;
            sel_write = 1'b1;
        end else if (grant[`EMRA_RQ_F]) begin
            sel_addr = addr_f;
            sel_write = 1'b1;
        end else if (grant[`EMRA_RQ_D]) begin
            sel_addr = addr_d;
        end else if (grant[`EMRA_RQ_C]) begin
            sel_addr = addr_c;
        end else if (grant[`EMRA_RQ_P]) begin
            sel_addr = addr_p;
        end else if (grant[`EMRA_RQ_DMA]) begin
            sel_addr = addr_dma;
            sel_write = dma_write;
        end
        sel_type = mem_types[3*space_of(sel_addr)+:3];
    end

    wire is_refresh = grant[`EMRA_RQ_URG] | grant[`EMRA_RQ_TRK];
    wire have_grant = |grant;
    wire sel_bad = !is_refresh && (sel_write && sel_type == `EMRA_MT_ASYNC8
        || sel_type != `EMRA_MT_ASYNC8 && sel_type != `EMRA_MT_ASYNC16
        && sel_type != `EMRA_MT_SDRAM);
    wire need_dead = last_valid && !is_refresh
        && (space_of(sel_addr) != last_space || sel_write != last_write);

    // ****************************************
    // Control state machine
    // ****************************************
    always @* begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (hold_req) begin
                    next_state = ST_DEACT;
                end else if (have_grant && !sel_bad) begin
                    if (is_refresh) begin
                        next_state = ST_RFSH;
                    end else if (need_dead) begin
                        next_state = ST_DEAD;
                    end else begin
                        next_state = ST_ACC;
                    end
                end
            end
            ST_ACC: begin
                if (cnt == 4'h0) begin
                    next_state = cur_async ? ST_DEAD : ST_IDLE;
                end
            end
            ST_RFSH: begin
                if (cnt == 4'h0) begin
                    next_state = ST_IDLE;
                end
            end
            ST_DEAD: begin
                next_state = ST_IDLE;
            end
            ST_DEACT: begin
                if (cnt == 4'h0) begin
                    next_state = ST_HELD;
                end
            end
            ST_HELD: begin
                if (!hold_req) begin
                    next_state = ST_IDLE;
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            state <= ST_HELD;
            hold_req <= 1'b0;
            ack_n <= 1'b1;
            mem_types <= `EMRA_TYPE_RST;
            pend <= {`EMRA_NREQ{1'b0}};
            cnt <= 4'h0;
            last_space <= 2'h0;
            last_write <= 1'b0;
            last_valid <= 1'b0;
            cur <= {`EMRA_NREQ{1'b0}};
            cur_space <= 2'h0;
            cur_async <= 1'b0;
            after_hold <= 1'b0;
            req_done <= {`EMRA_NREQ{1'b0}};
            req_drop <= {`EMRA_NREQ{1'b0}};
            chip_space_n <= 4'hF;
            mem_addr <= {(AW+2){1'b0}};
            mem_write <= 1'b0;
            mem_long <= 1'b0;
            mem_busy <= 1'b0;
            mem_refresh <= 1'b0;
            mem_oe <= 1'b0;
            reg_rdata <= 16'h0000;
        end else begin
            state <= next_state;
            req_done <= {`EMRA_NREQ{1'b0}};
            req_drop <= {`EMRA_NREQ{1'b0}};
            // Held requests stay pending through a release
            pend <= (pend | req_in) & ~drop_mask;
            if (cnt != 4'h0) begin
                cnt <= cnt - 4'h1;
            end
            case (state)
                ST_IDLE: begin
                    chip_space_n <= 4'hF;
                    mem_busy <= 1'b0;
                    mem_refresh <= 1'b0;
                    // Refresh-first ordering ends once no refresh is due
                    if (after_hold && !refresh_due) begin
                        after_hold <= 1'b0;
                    end
                    if (!hold_req && have_grant) begin
                        if (sel_bad) begin
                            pend <= ((pend & ~grant) | req_in) & ~drop_mask;
                            req_drop <= grant;
                        end else if (is_refresh) begin
                            cur <= grant;
                            cnt <= `EMRA_ACC_CYC;
                            mem_refresh <= 1'b1;
                            mem_busy <= 1'b1;
                        end else if (!need_dead) begin
                            cur <= grant;
                            cnt <= ACC_CYC[3:0] - 4'h1;
                            cur_space <= space_of(sel_addr);
                            cur_async <= sel_type != `EMRA_MT_SDRAM;
                            last_space <= space_of(sel_addr);
                            last_write <= sel_write;
                            last_valid <= 1'b1;
                            mem_addr <= sel_addr;
                            mem_write <= sel_write;
                            mem_long <= req_long && (grant[`EMRA_RQ_D] || grant[`EMRA_RQ_E]);
                            mem_busy <= 1'b1;
                            chip_space_n <= ~(4'h1 << enable_of(space_of(sel_addr),
                                mem_types));
                        end else begin
                            last_valid <= 1'b0;
                        end
                    end
                    if (hold_req) begin
                        cnt <= DEACT_CYC[3:0];
                    end
                end
                ST_ACC: begin
                    if (cnt == 4'h0) begin
                        pend <= ((pend & ~cur) | req_in) & ~drop_mask;
                        req_done <= cur;
                        mem_busy <= 1'b0;
                        chip_space_n <= 4'hF;
                        if (cur_async) begin
                            last_valid <= 1'b0;
                        end
                    end
                end
                ST_RFSH: begin
                    if (cnt == 4'h0) begin
                        pend <= ((pend & ~cur) | req_in) & ~drop_mask;
                        req_done <= cur;
                        mem_refresh <= 1'b0;
                        mem_busy <= 1'b0;
                    end
                end
                ST_DEAD: begin
                    chip_space_n <= 4'hF;
                end
                ST_DEACT: begin
                    chip_space_n <= 4'hF;
                    if (cnt == 4'h0) begin
                        mem_oe <= 1'b0;
                        ack_n <= 1'b0;
                    end
                end
                ST_HELD: begin
                    chip_space_n <= 4'hF;
                    if (!hold_req) begin
                        mem_oe <= 1'b1;
                        after_hold <= 1'b1;
                        last_valid <= 1'b0;
                    end
                end
                default: begin
                    chip_space_n <= 4'hF;
                end
            endcase
            if (!hold_req) begin
                ack_n <= 1'b1;
            end
            // ****************************************
            // Register port
            // ****************************************
            if (reg_wr) begin
                case (reg_addr)
                    `EMRA_OFF_EXTERNAL_BUS_SELECT_REG: begin
                        hold_req <= reg_wdata[`EMRA_BIT_HOLD];
                        if (!reg_wdata[`EMRA_BIT_HOLD]) begin
                            ack_n <= 1'b1;
                        end
                    end
                    `EMRA_OFF_TYPE: begin
                        mem_types <= reg_wdata[11:0];
                    end
                    default: begin
                        mem_types <= mem_types;
                    end
                endcase
            end
            reg_rdata <= 16'h0000;
            if (reg_rd) begin
                case (reg_addr)
                    `EMRA_OFF_EXTERNAL_BUS_SELECT_REG: reg_rdata <= {14'h0000, ack_n, hold_req};
                    `EMRA_OFF_TYPE: reg_rdata <= {4'h0, mem_types};
                    `EMRA_OFF_STAT: reg_rdata <= {13'h0000, state};
                    `EMRA_OFF_RPEND: reg_rdata <= {8'h00, pend};
                    default: reg_rdata <= 16'h0000;
                endcase
            end
        end
    end
endmodule

// *** tb/emra_arbiter_asserts.sv ***
// Port checker for the request arbiter
`timescale 1ns/1ps
`include "emra_defs.vh"
module emra_arbiter_chk (
    input wire clk,
    input wire resetn,
    input wire [`EMRA_ADDR_W-1:0] reg_addr,
    input wire [15:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    input wire [15:0] reg_rdata,
    input wire [7:0] req_done,
    input wire [7:0] req_drop,
    input wire [3:0] chip_space_n,
    input wire mem_busy,
    input wire mem_refresh,
    input wire mem_oe
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);
    wire hold_set = reg_wr && reg_addr == `EMRA_OFF_EXTERNAL_BUS_SELECT_REG && reg_wdata[0];
    wire hold_clr = reg_wr && reg_addr == `EMRA_OFF_EXTERNAL_BUS_SELECT_REG && !reg_wdata[0];
    wire cs_on = chip_space_n != 4'hF;
    sequence two_on;
        cs_on ##1 cs_on;
    endsequence
    chk_released_enables_off: assert property (!mem_oe |-> chip_space_n == 4'hF)
        else $error("enable low while pins released");
    chk_no_held_refresh: assert property (!mem_oe |-> !mem_refresh)
        else $error("refresh while released");
    chk_single_enable: assert property ($countones(~chip_space_n) <= 1)
        else $error("two enables low");
    chk_enable_in_access: assert property (cs_on |-> mem_busy)
        else $error("enable low outside an access");
    chk_space_change_dead: assert property (two_on |-> $stable(chip_space_n))
        else $error("space change without idle cycle");
    chk_ack_forced_high: assert property (
        hold_clr ##2 (reg_rd && reg_addr == `EMRA_OFF_EXTERNAL_BUS_SELECT_REG) |=> reg_rdata[`EMRA_BIT_ACKN])
        else $error("ack bit not back to one");
    chk_release_bounded: assert property (hold_set |-> ##[1:60] !mem_oe)
        else $error("release not entered");
    chk_resume_drive: assert property (hold_clr |-> ##[1:2] mem_oe)
        else $error("pins not driven again");
    chk_rdata_quiet: assert property (!reg_rd |=> reg_rdata == 16'h0000)
        else $error("read data outside read cycle");
    chk_one_done: assert property ($onehot0(req_done))
        else $error("two requests served at once");
    cov_release: cover property ($fell(mem_oe));
    cov_drop: cover property (req_drop != 8'h00);
    cov_refresh: cover property ($rose(mem_refresh));
endmodule
bind emra_arbiter emra_arbiter_chk emra_arbiter_chk_inst (.clk(clk), .resetn(resetn),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .req_done(req_done), .req_drop(req_drop),
    .chip_space_n(chip_space_n), .mem_busy(mem_busy), .mem_refresh(mem_refresh),
    .mem_oe(mem_oe));

// *** tb/emra_ext_master.sv ***
// External master that uses the memory pins while the arbiter is released
`timescale 1ns/1ps
module emra_ext_master #(
    parameter LAG = 2
) (
    input wire clk,
    input wire resetn,
    input wire mem_oe,
    input wire granted,
    output reg [7:0] clash
);
    reg [3:0] lag_cnt;
    reg drive;
    // Drives only after the grant and a lag; counts cycles both sides drive
    always @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            lag_cnt <= 4'h0;
            drive <= 1'b0;
            clash <= 8'h00;
        end else begin
            lag_cnt <= !granted ? 4'h0 : (lag_cnt == LAG ? lag_cnt : lag_cnt + 4'h1);
            drive <= granted && lag_cnt == LAG;
            if (drive && mem_oe && clash != 8'hFF) begin
                clash <= clash + 8'h01;
            end
        end
    end
endmodule

// *** tb/emra_arbiter_test.sv ***
// Self-checking bench for the request arbiter
`timescale 1ns/1ps
`include "emra_defs.vh"
module emra_arbiter_test;
    reg clk = 1'b0;
    reg resetn = 1'b0;
    reg [3:0] reg_addr = 4'h0;
    reg [15:0] reg_wdata = 16'h0000;
    reg reg_wr = 1'b0;
    reg reg_rd = 1'b0;
    reg req_long = 1'b0;
    reg granted = 1'b0;
    reg [7:0] req_in = 8'h00;
    reg [23:0] addr_de = 24'h0;
    reg [23:0] addr_cf = 24'h0;
    wire [15:0] reg_rdata;
    wire [7:0] req_done;
    wire [7:0] req_drop;
    wire [7:0] clash;
    wire [3:0] chip_space_n;
    wire [23:0] mem_addr;
    wire mem_oe;
    wire mem_write;
    wire mem_long;
    reg last_wr = 1'b0;
    reg last_long = 1'b0;
    logic [7:0] done_q[$];
    reg [7:0] dropped = 8'h00;
    reg [3:0] last_cs = 4'hF;
    reg [23:0] last_addr = 24'h0;
    integer err_total = 0;
    integer samples_checked = 0;
    integer cyc = 0;
    integer i;
    always #12.5 clk = ~clk;
    emra_arbiter emra_arbiter_inst (.clk(clk), .resetn(resetn), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .req_in(req_in), .req_long(req_long), .addr_e(addr_de), .addr_f(addr_cf),
        .addr_d(addr_de), .addr_c(addr_cf), .addr_p(addr_cf), .addr_dma(addr_cf),
        .dma_write(1'b0), .req_done(req_done), .req_drop(req_drop),
        .chip_space_n(chip_space_n), .mem_addr(mem_addr), .mem_write(mem_write),
        .mem_long(mem_long), .mem_busy(), .mem_refresh(), .mem_oe(mem_oe));
    emra_ext_master emra_ext_master_inst (.clk(clk), .resetn(resetn), .mem_oe(mem_oe),
        .granted(granted), .clash(clash));
    // ****************************************
    // Monitor and watchdog
    // ****************************************
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (req_done != 8'h00) begin
            done_q.push_back(req_done);
        end
        dropped <= dropped | req_drop;
        if (chip_space_n != 4'hF) begin
            last_cs <= chip_space_n;
            last_addr <= mem_addr;
            last_wr <= mem_write;
            last_long <= mem_long;
        end
        if (cyc == 20000) begin
            err_total++;
            end_sim;
        end
    end
    // ****************************************
    // Tasks
    // ****************************************
    task chk(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task pop(input logic [7:0] exp);
        logic [7:0] v;
        v = done_q.size() ? done_q.pop_front() : 8'hXX;
        chk({8'h00, v}, {8'h00, exp});
    endtask
    task wr(input [3:0] a, input [15:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task rd(input [3:0] a, input [15:0] exp);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata, exp);
    endtask
    task req(input [7:0] b, input lg, input [23:0] a);
        @(posedge clk);
        req_in <= b;
        req_long <= lg;
        addr_de <= a;
        addr_cf <= a + 24'h2;
        @(posedge clk);
        req_in <= 8'h00;
        req_long <= 1'b0;
    endtask
    task wait_n(input integer n);
        for (int k = 0; k < 300 && done_q.size() < n; k++) @(posedge clk);
        repeat (10) @(posedge clk);
    endtask
    task end_sim;
        $display("compared %0d mismatched %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // ****************************************
    // Tests
    // ****************************************
    initial begin
        repeat (8) @(posedge clk);
        resetn <= 1'b1;
        rd(4'h0, 16'h0002);
        rd(4'h1, 16'h0249);
        rd(4'hF, 16'h0000);
        $display("test reset values done");
        req(8'h82, 1'b0, 24'h000000);
        wait_n(2);
        pop(8'h02);
        pop(8'h80);
        $display("test refresh order done");
        req(8'hFF, 1'b0, 24'h0);
        wait_n(8);
        for (i = 0; i < 8; i++) pop(8'h01 << i);
        $display("test priority done");
        for (i = 0; i < 4; i++) begin
            req(8'h08, 1'b0, {i[1:0], 22'h0});
            wait_n(1);
            pop(8'h08);
            chk({12'h0, last_cs}, {12'h0, ~(4'h1 << i)});
        end
        $display("test spaces done");
        wr(4'h1, 16'h06C1);
        rd(4'h1, 16'h06C1);
        req(8'h08, 1'b0, 24'hC00000);
        wait_n(1);
        pop(8'h08);
        chk({12'h0, last_cs}, 16'h000B);
        req(8'h02, 1'b0, 24'h400000);
        wait_n(1);
        chk({8'h00, dropped}, 16'h0002);
        chk(16'(done_q.size()), 16'h0000);
        req(8'h08, 1'b0, 24'h400010);
        wait_n(1);
        pop(8'h08);
        wr(4'h1, 16'h0249);
        $display("test memory types done");
        req(8'h18, 1'b1, 24'h000100);
        wait_n(1);
        pop(8'h08);
        chk(16'(done_q.size()), 16'h0000);
        chk(last_addr[15:0], 16'h0100);
        chk({14'h0000, last_wr, last_long}, 16'h0001);
        req(8'h06, 1'b1, 24'h000200);
        wait_n(1);
        pop(8'h02);
        chk(16'(done_q.size()), 16'h0000);
        chk(last_addr[15:0], 16'h0200);
        chk({14'h0000, last_wr, last_long}, 16'h0003);
        req(8'h18, 1'b0, 24'h000300);
        wait_n(2);
        pop(8'h08);
        pop(8'h10);
        chk(last_addr[15:0], 16'h0302);
        chk({14'h0000, last_wr, last_long}, 16'h0000);
        $display("test long and dual done");
        wr(4'h0, 16'h0001);
        repeat (20) @(posedge clk);
        rd(4'h0, 16'h0001);
        @(posedge clk);
        granted <= 1'b1;
        req(8'h88, 1'b0, 24'h000400);
        repeat (30) @(posedge clk);
        chk(16'(done_q.size()), 16'h0000);
        granted <= 1'b0;
        repeat (3) @(posedge clk);
        wr(4'h0, 16'h0000);
        rd(4'h0, 16'h0002);
        wait_n(2);
        pop(8'h80);
        pop(8'h08);
        chk({8'h00, clash}, 16'h0000);
        $display("test release done");
        end_sim;
    end
endmodule
